/* File: design/dsc_pkg.sv */
// dsc_pkg: constants for the debug status and control register block.
// assumes one processor clock domain; the version choice is a module parameter.
// Behaviour
// - external view is register 34, offset 0x088
// - internal coprocessor view and external port view
// - views differ only in permission, transfer flags; here both views read one common image
// - bits 30/29 show transfer registers full
// - bits 27/26 latched copies of full flags
// - bit 25 pipeline advance, bit 24 complete
// - bits 21:20 access mode, external write only
// - bit 19 discards imprecise aborts, resets 0
// - bits 18:16 reflect security state inputs
// - bit 15 monitor mode, internally writable
// - bits 14/13 halting and execute, external write
// - bit 12 user comms disable, internal write
// - bits 11/10 interrupt disable, force acknowledge
// - bit 9 no power down, reserved later
// - sticky bits 8:6, clear by version
// - bits 5:2 entry method, read-write, reset 0
// - older version: each bit written via one view, except bits 5:2 written via both
// - newer version: internal view fully read-only
// - bit 0 shows debug state
// - bit 1 low only while restarting
// - entry method codes per debug event
package dsc_pkg;
    localparam logic [11:0] DSC_OFFSET     = 12'h088;  // byte offset of the register
    localparam int          DSC_REG_NUM    = 34;       // register number in debug space
    localparam int          B_RX_FULL      = 30;
    localparam int          B_TX_FULL      = 29;
    localparam int          B_RX_LATCHED   = 27;
    localparam int          B_TX_LATCHED   = 26;
    localparam int          B_PIPE_ADV     = 25;
    localparam int          B_INSTR_CMPL   = 24;
    localparam int          B_ACC_MODE_LO  = 20;
    localparam int          B_IMP_DISCARD  = 19;
    localparam int          B_NONSECURE    = 18;
    localparam int          B_SNI_OFF      = 17;
    localparam int          B_SI_OFF       = 16;
    localparam int          B_MONITOR_EN   = 15;
    localparam int          B_HALTING_EN   = 14;
    localparam int          B_EXEC_EN      = 13;
    localparam int          B_COMMS_DIS    = 12;
    localparam int          B_INT_DIS      = 11;
    localparam int          B_FORCE_ACK    = 10;
    localparam int          B_NO_PWRDN     = 9;
    localparam int          B_STICKY_UNDEF = 8;
    localparam int          B_STICKY_IMP   = 7;
    localparam int          B_STICKY_PREC  = 6;
    localparam int          B_ENTRY_LO     = 2;
    localparam int          B_RESTARTED    = 1;
    localparam int          B_HALTED       = 0;
    localparam logic [1:0]  ACC_MODE_RST   = 2'h0;
    localparam logic [3:0]  ENTRY_RST      = 4'h0;
    localparam logic        RESTARTED_RST  = 1'b1;
    localparam logic        PIPE_ADV_RST   = 1'b0;  // unpredictable; zero chosen
    localparam logic        INSTR_CMPL_RST = 1'b1;  // unpredictable; one chosen
    // entry method codes
    localparam logic [3:0]  ENTRY_HALT_REQ = 4'h0;
    localparam logic [3:0]  ENTRY_BREAKPT  = 4'h1;
    localparam logic [3:0]  ENTRY_BKPT_INS = 4'h3;
    localparam logic [3:0]  ENTRY_EXT_REQ  = 4'h4;
    localparam logic [3:0]  ENTRY_VEC_CTCH = 4'h5;
    // debug event kinds presented on the entry input
    typedef enum logic [4:0] {
        DSC_EV_HALT_REQ = 5'h01,
        DSC_EV_BREAKPT  = 5'h02,
        DSC_EV_BKPT_INS = 5'h04,
        DSC_EV_EXT_REQ  = 5'h08,
        DSC_EV_VEC_CTCH = 5'h10
    } dsc_event_t;
endpackage : dsc_pkg

/* File: design/dsc_debug_status_control.sv */
// dsc_debug_status_control: the debug status and control register, two views.
// assumes all status and event inputs come from logic on mclk (no synchronisers);
// the external view is a simple select/write port, the internal one a coprocessor port.
`timescale 1ns/10ps
module dsc_debug_status_control #(
    parameter bit VERSION7   = 1'b1,  // 1: newer debug version, 0: older version
    parameter bit DISCARD_RW = 1'b1   // bit 19 writable (1) or read-only (0)
) (
    input  wire logic              mclk,             // processor clock, 200 MHz
    input  wire logic              rst_n,            // debug reset, async, active low
    input  wire logic              ext_sel,          // external port access strobe
    input  wire logic              ext_write,        // 1 write, 0 read
    input  wire logic [11:0]       ext_addr,         // byte address in debug space
    input  wire logic [31:0]       ext_wdata,        // external write data
    output logic [31:0]            ext_rdata,        // external read data
    output logic                   ext_rvalid,       // read data valid pulse
    input  wire logic              int_read,         // coprocessor read strobe
    input  wire logic              int_write,        // coprocessor write strobe
    input  wire logic [31:0]       int_wdata,        // coprocessor write data
    output logic [31:0]            int_rdata,        // coprocessor read data
    output logic                   int_rvalid,       // coprocessor read valid pulse
    input  wire logic              rx_transfer_full, // receive transfer reg holds data
    input  wire logic              tx_transfer_full, // transmit transfer reg holds data
    input  wire logic              pipe_advance,     // pipeline advanced pulse
    input  wire logic              instr_complete,   // last instruction completed level
    input  wire logic              nonsecure_state,  // current world is non-secure
    input  wire logic              secure_noninvasive_debug_off, // status level
    input  wire logic              secure_invasive_debug_off,    // status level
    input  wire logic              undef_event,      // undefined instr in debug state
    input  wire logic              imp_abort_event,  // imprecise abort in debug state
    input  wire logic              prec_abort_event, // precise abort in debug state
    input  wire logic              run_ctrl_clear,   // run-control sticky clear pulse
    input  wire logic              core_halted,      // processor is in debug state
    input  wire logic              entry_valid,      // debug entry pulse
    input  wire dsc_pkg::dsc_event_t entry_event,    // kind of debug event
    input  wire logic              exit_request,     // request to leave debug state
    input  wire logic              core_restarted,   // normal execution restarted
    output logic                   monitor_en,       // monitor debug-mode enabled
    output logic                   halting_en,       // halting debug-mode enabled
    output logic                   exec_en,          // execute debugger instructions
    output logic                   comms_user_dis,   // user access to comms disabled
    output logic                   interrupt_disable,        // interrupts masked
    output logic                   force_debug_acknowledge,  // force ack output
    output logic                   no_power_down_request,    // older version only
    output logic                   imp_discard,      // discard imprecise aborts
    output logic [1:0]             access_mode       // external transfer access mode
);
    import dsc_pkg::*;

    logic [31:0] image;
    logic        ext_hit;
    logic        ext_rd;
    logic        ext_wr;
    logic        int_wr;
    logic [3:0]  entry_code;
    logic        rx_latched_reg;
    logic        tx_latched_reg;
    logic        pipe_adv_reg;
    logic        instr_cmpl_reg;
    logic        sticky_undef_reg;
    logic        sticky_imp_reg;
    logic        sticky_prec_reg;
    logic [3:0]  entry_reg;
    logic        restarted_reg;
    logic        clr_sticky;

    // map a debug event kind onto its entry method code
    function automatic logic [3:0] entry_of(input dsc_event_t ev);
        case (ev)
            DSC_EV_HALT_REQ: entry_of = ENTRY_HALT_REQ;
            DSC_EV_BREAKPT:  entry_of = ENTRY_BREAKPT;
            DSC_EV_BKPT_INS: entry_of = ENTRY_BKPT_INS;
            DSC_EV_EXT_REQ:  entry_of = ENTRY_EXT_REQ;
            DSC_EV_VEC_CTCH: entry_of = ENTRY_VEC_CTCH;
            default:         entry_of = ENTRY_HALT_REQ;
        endcase
    endfunction : entry_of

    // access decode; only offset 0x088 answers, others read zero and ignore writes
    assign ext_hit    = (ext_addr == DSC_OFFSET);
    assign ext_rd     = ext_sel && !ext_write && ext_hit;
    assign ext_wr     = ext_sel && ext_write && ext_hit;
    assign int_wr     = int_write && !VERSION7;
    assign entry_code = entry_of(entry_event);
    // older version clears sticky flags by an external read, newer by run control
    assign clr_sticky = VERSION7 ? run_ctrl_clear : ext_rd;

    // assemble the common image; reserved bits stay zero
    always_comb
    begin
        image                   = 32'h0000_0000;
        image[B_RX_FULL]        = rx_transfer_full;
        image[B_TX_FULL]        = tx_transfer_full;
        image[B_RX_LATCHED]     = VERSION7 && rx_latched_reg;
        image[B_TX_LATCHED]     = VERSION7 && tx_latched_reg;
        image[B_PIPE_ADV]       = VERSION7 && pipe_adv_reg;
        image[B_INSTR_CMPL]     = VERSION7 && instr_cmpl_reg;
        image[B_ACC_MODE_LO+:2] = access_mode;
        image[B_IMP_DISCARD]    = imp_discard;
        image[B_NONSECURE]      = nonsecure_state;
        image[B_SNI_OFF]        = secure_noninvasive_debug_off;
        image[B_SI_OFF]         = secure_invasive_debug_off;
        image[B_MONITOR_EN]     = monitor_en;
        image[B_HALTING_EN]     = halting_en;
        image[B_EXEC_EN]        = exec_en;
        image[B_COMMS_DIS]      = comms_user_dis;
        image[B_INT_DIS]        = interrupt_disable;
        image[B_FORCE_ACK]      = force_debug_acknowledge;
        image[B_NO_PWRDN]       = no_power_down_request;
        image[B_STICKY_UNDEF]   = sticky_undef_reg;
        image[B_STICKY_IMP]     = sticky_imp_reg;
        image[B_STICKY_PREC]    = sticky_prec_reg;
        image[B_ENTRY_LO+:4]    = entry_reg;
        image[B_RESTARTED]      = restarted_reg;
        image[B_HALTED]         = core_halted;
    end

    // both views return the same image one cycle after the strobe
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ext_rdata  <= 32'h0000_0000;
            ext_rvalid <= 1'b0;
            int_rdata  <= 32'h0000_0000;
            int_rvalid <= 1'b0;
        end
        else
        begin
            ext_rvalid <= ext_sel && !ext_write;
            ext_rdata  <= ext_rd ? image : 32'h0000_0000;
            int_rvalid <= int_read;
            int_rdata  <= int_read ? image : 32'h0000_0000;
        end
    end

    // latched copies: only an external read refreshes them, so the debugger
    // sees what the flags were at its last read, not at a coprocessor read
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_latched_reg <= 1'b0;
            tx_latched_reg <= 1'b0;
            instr_cmpl_reg <= INSTR_CMPL_RST;
        end
        else if (ext_rd)
        begin
            rx_latched_reg <= rx_transfer_full;
            tx_latched_reg <= tx_transfer_full;
            instr_cmpl_reg <= instr_complete;
        end
    end

    // sticky pipeline advance, cleared by run_ctrl_clear in both versions, not by clr_sticky
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            pipe_adv_reg <= PIPE_ADV_RST;
        else if (pipe_advance)
            pipe_adv_reg <= 1'b1;
        else if (run_ctrl_clear)
            pipe_adv_reg <= 1'b0;
    end

    // sticky abort and undefined flags; a set in the clear cycle wins
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sticky_undef_reg <= 1'b0;
            sticky_imp_reg   <= 1'b0;
            sticky_prec_reg  <= 1'b0;
        end
        else
        begin
            sticky_undef_reg <= undef_event || (sticky_undef_reg && !clr_sticky);
            sticky_imp_reg   <= imp_abort_event || (sticky_imp_reg && !clr_sticky);
            sticky_prec_reg  <= prec_abort_event || (sticky_prec_reg && !clr_sticky);
        end
    end

    // control bits written through the external view
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            halting_en              <= 1'b0;
            exec_en                 <= 1'b0;
            interrupt_disable       <= 1'b0;
            force_debug_acknowledge <= 1'b0;
            no_power_down_request   <= 1'b0;
            access_mode             <= ACC_MODE_RST;
            imp_discard             <= 1'b0;
        end
        else if (ext_wr)
        begin
            halting_en              <= ext_wdata[B_HALTING_EN];
            exec_en                 <= ext_wdata[B_EXEC_EN];
            interrupt_disable       <= ext_wdata[B_INT_DIS];
            force_debug_acknowledge <= ext_wdata[B_FORCE_ACK];
            // newer version keeps bit 9 reserved, so it never sets
            no_power_down_request   <= !VERSION7 && ext_wdata[B_NO_PWRDN];
            access_mode             <= VERSION7 ? ext_wdata[B_ACC_MODE_LO+:2]
                                                : ACC_MODE_RST;
            if (DISCARD_RW)
                imp_discard <= ext_wdata[B_IMP_DISCARD];
        end
    end

    // internal-view bits: older version writes them by coprocessor only,
    // newer version has a read-only internal view so the external one takes over
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            monitor_en     <= 1'b0;
            comms_user_dis <= 1'b0;
        end
        else if (int_wr)
        begin
            monitor_en     <= int_wdata[B_MONITOR_EN];
            comms_user_dis <= int_wdata[B_COMMS_DIS];
        end
        else if (VERSION7 && ext_wr)
        begin
            monitor_en     <= ext_wdata[B_MONITOR_EN];
            comms_user_dis <= ext_wdata[B_COMMS_DIS];
        end
    end

    // entry method: hardware load on debug entry outranks a software write
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            entry_reg <= ENTRY_RST;
        else if (entry_valid)
            entry_reg <= entry_code;
        else if (ext_wr)
            entry_reg <= ext_wdata[B_ENTRY_LO+:4];
        else if (int_wr)
            entry_reg <= int_wdata[B_ENTRY_LO+:4];
    end

    // restarted flag: low only from exit request until execution restarts
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            restarted_reg <= RESTARTED_RST;
        else if (core_restarted)
            restarted_reg <= 1'b1;
        else if (exit_request)
            restarted_reg <= 1'b0;
    end

    default clocking dsc_cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    property p_read_image;
        ext_rd |=> ext_rvalid && ext_rdata[B_HALTED] == $past(core_halted);
    endproperty
    a_read_image: assert property (p_read_image) else $error("external read image wrong");

    // the coprocessor view must carry the same live halted bit
    property p_int_image;
        int_read |=> int_rvalid && int_rdata[B_HALTED] == $past(core_halted);
    endproperty
    a_int_image: assert property (p_int_image) else $error("internal read image wrong");

    property p_unmapped_zero;
        ext_sel && !ext_write && !ext_hit |=> ext_rdata == 32'h0000_0000;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

    property p_reserved_zero;
        int_rvalid |-> int_rdata[31] == 1'b0 && int_rdata[28] == 1'b0
                       && int_rdata[23:22] == 2'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

    property p_int_readonly;
        VERSION7 && int_write && !ext_wr |=> $stable(monitor_en) && $stable(comms_user_dis);
    endproperty
    a_int_readonly: assert property (p_int_readonly) else $error("internal write took");

    property p_ext_write_ctrl;
        ext_wr |=> halting_en == $past(ext_wdata[B_HALTING_EN])
                   && interrupt_disable == $past(ext_wdata[B_INT_DIS]);
    endproperty
    a_ext_write_ctrl: assert property (p_ext_write_ctrl) else $error("control write lost");

    property p_sticky_set_wins;
        imp_abort_event && clr_sticky |=> sticky_imp_reg
                                          ##1 (sticky_imp_reg || $past(clr_sticky));
    endproperty
    a_sticky_set_wins: assert property (p_sticky_set_wins) else $error("sticky set lost");

    property p_sticky_clear;
        clr_sticky && !prec_abort_event |=> !sticky_prec_reg;
    endproperty
    a_sticky_clear: assert property (p_sticky_clear) else $error("sticky not cleared");

    property p_restart_low;
        // stepwise form: low after a request and held low until the restart pulse
        (exit_request || !restarted_reg) && !core_restarted |=> !restarted_reg;
    endproperty
    a_restart_low: assert property (p_restart_low) else $error("restarted rose early");

    property p_entry_code;
        entry_valid && entry_event == DSC_EV_VEC_CTCH |=> entry_reg == 4'h5;
    endproperty
    a_entry_code: assert property (p_entry_code) else $error("entry code wrong");

    property p_no_pwrdn_v7;
        VERSION7 |-> !no_power_down_request;
    endproperty
    a_no_pwrdn_v7: assert property (p_no_pwrdn_v7) else $error("bit 9 set in newer version");

    property p_latched_copy;
        // the copy shown by a read is the level seen at the previous external read
        ext_rd ##1 !ext_rd ##1 ext_rd
            |=> ext_rdata[B_RX_LATCHED] == (VERSION7 && $past(rx_transfer_full, 3));
    endproperty
    a_latched_copy: assert property (p_latched_copy) else $error("latched copy wrong");

    c_halt_seen:    cover property (ext_rvalid && ext_rdata[B_HALTED]);
    c_restart_seq:  cover property (exit_request ##[1:20] core_restarted);
    c_sticky_clear: cover property (sticky_prec_reg ##1 !sticky_prec_reg);
    c_ctrl_write:   cover property (ext_wr && ext_wdata[B_HALTING_EN]);

endmodule : dsc_debug_status_control

/* File: testbench/dsc_debugger.sv */
// dsc_debugger: behavioural external debugger on the debug access port.
// assumes the block answers reads one cycle after the strobe edge, single words only.
`timescale 1ns/10ps
module dsc_debugger (
    input  wire logic        mclk,       // processor clock
    input  wire logic [31:0] ext_rdata,  // read data from the block
    input  wire logic        ext_rvalid, // read data valid pulse
    output logic             ext_sel,    // access strobe
    output logic             ext_write,  // 1 write, 0 read
    output logic [11:0]      ext_addr,   // byte address
    output logic [31:0]      ext_wdata,  // write data
    output logic             timed_out   // an answer or a poll never came
);
    import dsc_pkg::*;
    // idle bus at time zero
    initial
    begin
        ext_sel = 1'b0;
        ext_write = 1'b0;
        ext_addr = 12'h000;
        ext_wdata = 32'h0000_0000;
        timed_out = 1'b0;
    end
    // one word per access; released lines flip so stale values never look valid
    task automatic access(input logic wr, input logic [11:0] a, input logic [31:0] d,
                          output logic [31:0] q);
        int i;
        q = 'x;
        ext_sel = 1'b1;
        ext_write = wr;
        ext_addr = a;
        ext_wdata = d;
        @(posedge mclk);
        #1;
        ext_sel = 1'b0;
        ext_addr = ~a;
        ext_wdata = ~d;
        for (i = 0; i < 4 && !wr; i++)
        begin
            if (ext_rvalid === 1'b1)
            begin
                q = ext_rdata;
                break;
            end
            @(posedge mclk);
            #1;
        end
        if (!wr && i == 4)
            timed_out = 1'b1;
        @(posedge mclk);  // gap so the strobe is never reassigned in one step
        #1;
    endtask : access
    // poll one status bit until it shows the wanted level, bounded
    task automatic poll(input int b, input logic v, output logic [31:0] q);
        int n;
        for (n = 0; n < 40; n++)
        begin
            access(1'b0, DSC_OFFSET, 32'h0000_0000, q);
            if (q[b] === v)
                break;
        end
        if (n == 40)
            timed_out = 1'b1;
    endtask : poll
endmodule : dsc_debugger

/* File: testbench/dsc_debug_status_control_test.sv */
// dsc_debug_status_control_test: self-checking bench for the status/control register.
// assumes default parameters (newer version, bit 19 writable) and a 200 MHz clock.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module dsc_debug_status_control_test;
    import dsc_pkg::*;
    logic        mclk, rst_n, ext_sel, ext_write, ext_rvalid, int_read, int_write, int_rvalid;
    logic [11:0] ext_addr;
    logic [31:0] ext_wdata, ext_rdata, int_wdata, int_rdata, q;
    logic        rx_transfer_full, tx_transfer_full, pipe_advance, instr_complete;
    logic        nonsecure_state, secure_noninvasive_debug_off, secure_invasive_debug_off;
    logic        undef_event, imp_abort_event, prec_abort_event, run_ctrl_clear;
    logic        core_halted, entry_valid, exit_request, core_restarted, timed_out;
    logic        monitor_en, halting_en, exec_en, comms_user_dis, interrupt_disable;
    logic        force_debug_acknowledge, no_power_down_request, imp_discard;
    logic [1:0]  access_mode;
    dsc_event_t  entry_event;
    int          n_mismatch, compares;
    dsc_debug_status_control dut (.mclk, .rst_n, .ext_sel, .ext_write, .ext_addr,
        .ext_wdata, .ext_rdata, .ext_rvalid, .int_read, .int_write, .int_wdata, .int_rdata,
        .int_rvalid, .rx_transfer_full, .tx_transfer_full, .pipe_advance, .instr_complete,
        .nonsecure_state, .secure_noninvasive_debug_off, .secure_invasive_debug_off,
        .undef_event, .imp_abort_event, .prec_abort_event, .run_ctrl_clear, .core_halted,
        .entry_valid, .entry_event, .exit_request, .core_restarted, .monitor_en,
        .halting_en, .exec_en, .comms_user_dis, .interrupt_disable,
        .force_debug_acknowledge, .no_power_down_request, .imp_discard, .access_mode);
    dsc_debugger dbg (.mclk, .ext_rdata, .ext_rvalid, .ext_sel, .ext_write, .ext_addr,
        .ext_wdata, .timed_out);
    // 5 ns clock
    always #2.5 mclk = ~mclk;
    task automatic tick;
        @(posedge mclk);
        #1;
    endtask : tick
    task automatic rd(output logic [31:0] d);
        dbg.access(1'b0, DSC_OFFSET, 32'h0000_0000, d);
    endtask : rd
    task automatic wr(input logic [31:0] d);
        dbg.access(1'b1, DSC_OFFSET, d, q);
    endtask : wr
    // coprocessor read, answer awaited under a bound
    task automatic int_rd(output logic [31:0] d);
        int i;
        d = 'x;
        int_read = 1'b1;
        tick;
        int_read = 1'b0;
        for (i = 0; i < 4 && int_rvalid !== 1'b1; i++)
            tick;
        if (i < 4)
            d = int_rdata;
        else
        begin
            n_mismatch++;
            wrap_up;
        end
        tick;
    endtask : int_rd
    task automatic t_reset;
        rd(q);
        `CHK("reset image", 32'h0000_0002, q & 32'hFCFF_FFFF)
        `CHK("reset outputs", 10'h000, {monitor_en, halting_en, exec_en, comms_user_dis,
            interrupt_disable, force_debug_acknowledge, no_power_down_request,
            imp_discard, access_mode})
        $display("done t_reset");
    endtask : t_reset
    task automatic t_live;
        rx_transfer_full = 1'b1;
        instr_complete = 1'b1;
        nonsecure_state = 1'b1;
        secure_invasive_debug_off = 1'b1;
        core_halted = 1'b1;
        tick;
        rd(q);
        `CHK("live bits", 32'h4005_0003, q & 32'h7007_0003)
        rd(q);
        `CHK("latched rx full", 4'b1001, q[27:24])
        int_rd(q);
        `CHK("internal status", 32'h0005_0003, q & 32'h0007_0003)
        rx_transfer_full = 1'b0;
        instr_complete = 1'b0;
        nonsecure_state = 1'b0;
        secure_invasive_debug_off = 1'b0;
        core_halted = 1'b0;
        $display("done t_live");
    endtask : t_live
    task automatic t_write;
        wr(32'hFFFF_FFFF);
        `CHK("written outputs", 10'h3F7, {monitor_en, halting_en, exec_en, comms_user_dis,
            interrupt_disable, force_debug_acknowledge, no_power_down_request,
            imp_discard, access_mode})
        rd(q);
        `CHK("written image", 32'h0038_FC3E, q & 32'hF0FF_FFFF)
        int_wdata = 32'h0000_0000;
        int_write = 1'b1;
        tick;
        int_write = 1'b0;
        tick;
        rd(q);
        `CHK("internal write", 32'h0038_FC3E, q & 32'hF0FF_FFFF)
        wr(32'h0008_0000);
        rd(q);
        `CHK("cleared image", 32'h0008_0002, q & 32'hF0FF_FFFF)
        $display("done t_write");
    endtask : t_write
    // bit 19 stays set from t_write; imprecise aborts are flagged whether it is set or not
    task automatic t_sticky;
        core_halted = 1'b1;
        {undef_event, imp_abort_event, prec_abort_event, pipe_advance} = 4'hF;
        tick;
        {undef_event, imp_abort_event, prec_abort_event, pipe_advance} = 4'h0;
        rd(q);
        `CHK("sticky set", 32'h0200_01C0, q & 32'h0200_01C0)
        rd(q);
        `CHK("sticky after read", 32'h0200_01C0, q & 32'h0200_01C0)
        run_ctrl_clear = 1'b1;
        tick;
        run_ctrl_clear = 1'b0;
        rd(q);
        `CHK("sticky cleared", 32'h0000_0000, q & 32'h0200_01C0)
        // an abort in the very cycle of the clear must still be recorded
        {imp_abort_event, run_ctrl_clear} = 2'b11;
        tick;
        {imp_abort_event, run_ctrl_clear} = 2'b00;
        rd(q);
        `CHK("sticky set wins", 32'h0000_0080, q & 32'h0200_01C0)
        $display("done t_sticky");
    endtask : t_sticky
    task automatic t_entry;
        dsc_event_t evs[5] = '{DSC_EV_HALT_REQ, DSC_EV_BREAKPT, DSC_EV_BKPT_INS,
                                DSC_EV_EXT_REQ, DSC_EV_VEC_CTCH};
        logic [3:0] codes[5] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h5};
        for (int k = 4; k >= 0; k--)
        begin
            entry_event = evs[k];
            entry_valid = 1'b1;
            tick;
            entry_valid = 1'b0;
            rd(q);
            `CHK("entry code", codes[k], q[5:2])
        end
        $display("done t_entry");
    endtask : t_entry
    task automatic t_restart;
        dbg.poll(0, 1'b1, q);
        exit_request = 1'b1;
        tick;
        exit_request = 1'b0;
        rd(q);
        `CHK("exiting", 1'b0, q[1])
        core_restarted = 1'b1;
        tick;
        core_restarted = 1'b0;
        dbg.poll(1, 1'b1, q);
        `CHK("restarted", 2'b11, q[1:0])
        $display("done t_restart");
    endtask : t_restart
    task automatic t_unmapped;
        dbg.access(1'b1, 12'h08C, 32'hFFFF_FFFF, q);
        dbg.access(1'b0, 12'h08C, 32'h0000_0000, q);
        `CHK("unmapped read", 32'h0000_0000, q)
        rd(q);
        `CHK("unmapped write", 32'h0008_0000, q & 32'h0038_FC3C)
        $display("done t_unmapped");
    endtask : t_unmapped
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    // a lost answer or a stuck poll ends the run with a mismatch
    always @(posedge timed_out)
    begin
        n_mismatch++;
        wrap_up;
    end
    initial
    begin
        {mclk, rst_n, int_read, int_write, int_wdata} = '0;
        {rx_transfer_full, tx_transfer_full, pipe_advance, instr_complete} = 4'h0;
        {nonsecure_state, secure_noninvasive_debug_off, secure_invasive_debug_off} = 3'h0;
        {undef_event, imp_abort_event, prec_abort_event, run_ctrl_clear} = 4'h0;
        {core_halted, entry_valid, exit_request, core_restarted} = 4'h0;
        entry_event = DSC_EV_HALT_REQ;
        n_mismatch = 0;
        compares = 0;
        repeat (8) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        tick;
        t_reset;
        t_live;
        t_write;
        t_sticky;
        t_entry;
        t_restart;
        t_unmapped;
        wrap_up;
    end
endmodule : dsc_debug_status_control_test
